// >>> core/sram_bank_pkg.sv
// Package: constants for the muxed-address SRAM bank controller
package sram_bank_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int          ADDR_W       = 22;
  localparam int          MUX_W        = 11;
  localparam int          DATA_W       = 16;
  localparam int          BYTE_W       = 8;
  localparam int          BANKS        = 4;
  localparam int          BANK_SEL_W   = 2;
  localparam int          MODULE_WORDS = 131072;
  // ****************************************
  // Timing, in ns and in cycles at 100 MHz
  // ****************************************
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          T_ROW_NS      = 20;
  localparam int          T_HOLD_NS     = 10;
  localparam int          T_ACC_NS      = 70;
  localparam int          T_WR_NS       = 70;
  localparam int          ROW_CYC  = (T_ROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WR_CYC   = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W    = 4;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0]  CE_IDLE   = 4'h0;
  localparam logic [10:0] MUX_RESET = 11'h000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
endpackage

// >>> core/reset_sync.sv
// Module: two-stage reset release synchroniser
`timescale 1ns/100ps
module reset_sync (
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  output logic      rstn_o
);
  logic meta_n;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_n <= 1'b0;
      rstn_o <= 1'b0;
    end else begin
      meta_n <= 1'b1;
      rstn_o <= meta_n;
    end
  end
endmodule

// >>> core/phase_timer.sv
// Module: down-counter that times one phase of a memory cycle
`timescale 1ns/100ps
module phase_timer
  import sram_bank_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] count_i,
  output logic                  done_o
);
  logic [CNT_W-1:0] remain;

  // Load with the cycle count; done is high on the last cycle of the phase
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      remain <= '0;
    end else if (load_i) begin
      remain <= count_i;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  // Done looks only at the count, so the load logic that reads it forms no loop
  assign done_o = (remain <= CNT_W'(1));
endmodule

// >>> core/sram_bank_ctrl.sv
// Module: host controller driving four banks of bytewide SRAM over a muxed address bus
// Overview of operation
// - Row latch strobe high marks row address
// - Row captured at strobe falling edge
// - 22-bit address sent row then column
// - Four bank enables, only addressed bank
// - Banks of two 128Kx8 modules, low/high
// - Low write strobe, low byte on bus
// - High write strobe, high byte on bus
// - Low read gate enables low modules
// - High read gate enables high modules
// - One shared 16-bit bidirectional data bus
// - Only accessed in static addressing mode
`timescale 1ns/100ps
module sram_bank_ctrl
  import sram_bank_pkg::*;
#(
  parameter int ROW_CYCLES  = ROW_CYC,
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int ACC_CYCLES  = ACC_CYC,
  parameter int WR_CYCLES   = WR_CYC
) (
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  // User request side
  input  wire logic              sram_mode_i,
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [1:0]        req_byte_en_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  // Memory side
  output logic                   row_latch_strobe_o,
  output logic [MUX_W-1:0]       muxed_mem_addr_o,
  output logic [BANKS-1:0]       bank_enable_o,
  output logic                   write_low_strobe_n_o,
  output logic                   write_high_strobe_n_o,
  output logic                   read_low_gate_n_o,
  output logic                   read_high_gate_n_o,
  input  wire logic [DATA_W-1:0] mem_data_bus_i,
  output logic [DATA_W-1:0]      mem_data_bus_o,
  output logic [DATA_W-1:0]      mem_data_bus_oe_o
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rst_n;

  reset_sync u_rst (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .rstn_o     (rst_n)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  typedef enum logic [2:0] {
    IDLE,
    ROW,
    COL,
    STROBE,
    RELEASE
  } phase_e;

  phase_e                state;
  logic [ADDR_W-1:0]     addr;
  logic [DATA_W-1:0]     wdata;
  logic                  is_write;
  logic [1:0]            byte_en;
  logic                  phase_done;
  logic                  phase_load;
  logic [CNT_W-1:0]      phase_count;

  wire logic start = (state == IDLE) && req_valid_i && sram_mode_i;

  // Each phase starts by loading the timer with its own length
  always_comb begin
    phase_load  = 1'b0;
    phase_count = '0;
    if (start) begin
      phase_load  = 1'b1;
      phase_count = CNT_W'(ROW_CYCLES);
    end else if (phase_done) begin
      unique case (state)
        ROW: begin
          phase_load  = 1'b1;
          phase_count = CNT_W'(HOLD_CYCLES);
        end
        COL: begin
          phase_load  = 1'b1;
          phase_count = is_write ? CNT_W'(WR_CYCLES) : CNT_W'(ACC_CYCLES);
        end
        STROBE: begin
          phase_load  = 1'b1;
          phase_count = CNT_W'(HOLD_CYCLES);
        end
        IDLE, RELEASE: begin
          phase_load  = 1'b0;
        end
      endcase
    end
  end

  phase_timer u_timer (
    .core_clk_i (core_clk_i),
    .rstn_i     (rst_n),
    .load_i     (phase_load),
    .count_i    (phase_count),
    .done_o     (phase_done)
  );

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
    end else begin
      unique case (state)
        IDLE:    if (start) state <= ROW;
        ROW:     if (phase_done) state <= COL;
        COL:     if (phase_done) state <= STROBE;
        STROBE:  if (phase_done) state <= RELEASE;
        RELEASE: if (phase_done) state <= IDLE;
      endcase
    end
  end

  // Request is captured once, so address and data hold through the strobe
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr     <= '0;
      wdata    <= DATA_RESET;
      is_write <= 1'b0;
      byte_en  <= 2'b00;
    end else if (start) begin
      addr     <= req_addr_i;
      wdata    <= req_wdata_i;
      is_write <= req_write_i;
      byte_en  <= req_byte_en_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (state == RELEASE) && phase_done;
    end
  end

  // ****************************************
  // Address pins
  // ****************************************
  // Row is the upper 11 bits; the top two row bits pick the bank
  wire logic [MUX_W-1:0]      row_part  = addr[ADDR_W-1:MUX_W];
  wire logic [MUX_W-1:0]      col_part  = addr[MUX_W-1:0];
  wire logic [BANK_SEL_W-1:0] bank_sel  = addr[ADDR_W-1 -: BANK_SEL_W];

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      row_latch_strobe_o <= 1'b0;
      muxed_mem_addr_o   <= MUX_RESET;
    end else begin
      row_latch_strobe_o <= (state == ROW) && !phase_done;
      muxed_mem_addr_o   <= (state == ROW) ? row_part : col_part;
    end
  end

  // ****************************************
  // Bank enables and strobes
  // ****************************************
  wire logic active = (state == COL) || (state == STROBE);

  genvar gb;
  generate
    for (gb = 0; gb < BANKS; gb++) begin : g_bank
      always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          bank_enable_o[gb] <= CE_IDLE[gb];
        end else begin
          bank_enable_o[gb] <= active && (bank_sel == BANK_SEL_W'(gb));
        end
      end
    end
  endgenerate

  wire logic strobing = (state == STROBE) && !phase_done;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      write_low_strobe_n_o  <= 1'b1;
      write_high_strobe_n_o <= 1'b1;
      read_low_gate_n_o     <= 1'b1;
      read_high_gate_n_o    <= 1'b1;
    end else begin
      write_low_strobe_n_o  <= !(strobing && is_write && byte_en[0]);
      write_high_strobe_n_o <= !(strobing && is_write && byte_en[1]);
      read_low_gate_n_o     <= !(strobing && !is_write && byte_en[0]);
      read_high_gate_n_o    <= !(strobing && !is_write && byte_en[1]);
    end
  end

  // ****************************************
  // Data bus
  // ****************************************
  // Drive in column and strobe phases so data is set before the strobe falls
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mem_data_bus_o    <= DATA_RESET;
      mem_data_bus_oe_o <= '0;
    end else begin
      mem_data_bus_o    <= wdata;
      mem_data_bus_oe_o <= {{BYTE_W{is_write && active && byte_en[1]}},
                            {BYTE_W{is_write && active && byte_en[0]}}};
    end
  end

  // Sample on the last cycle with the read gate low
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= DATA_RESET;
    end else begin
      rsp_valid_o <= 1'b0;
      if ((state == STROBE) && phase_done && !is_write) begin
        rsp_valid_o <= 1'b1;
        rsp_rdata_o <= mem_data_bus_i;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_ROW_STROBE_ONLY_ROW: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    row_latch_strobe_o |-> bank_enable_o == '0)
    else $error("Row strobe overlaps bank enable");
  AST_ONE_BANK: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $onehot0(bank_enable_o))
    else $error("More than one bank enabled");
  AST_WRITE_NEEDS_BANK: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (!write_low_strobe_n_o || !write_high_strobe_n_o) |-> bank_enable_o != '0)
    else $error("Write strobe without bank enable");
  AST_ADDR_STABLE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (!write_low_strobe_n_o && $past(!write_low_strobe_n_o)) |-> $stable(muxed_mem_addr_o))
    else $error("Address moved during write");
  AST_NO_READ_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (!read_low_gate_n_o || !read_high_gate_n_o) |-> mem_data_bus_oe_o == '0)
    else $error("Bus driven during read");
  AST_LOW_DATA_DRIVEN: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(write_low_strobe_n_o) |-> mem_data_bus_oe_o[BYTE_W-1:0] == '1)
    else $error("Low byte not driven at write");
  AST_HIGH_DATA_DRIVEN: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(write_high_strobe_n_o) |-> mem_data_bus_oe_o[DATA_W-1:BYTE_W] == '1)
    else $error("High byte not driven at write");
  AST_ROW_THEN_COL: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(row_latch_strobe_o) |-> ##[1:8] bank_enable_o != '0)
    else $error("No column phase after row");
  AST_READ_LOW_GATE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !read_low_gate_n_o |-> write_low_strobe_n_o && bank_enable_o != '0)
    else $error("Low read gate misuse");
  AST_READ_HIGH_GATE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !read_high_gate_n_o |-> write_high_strobe_n_o && bank_enable_o != '0)
    else $error("High read gate misuse");
  // The latch and the modules have no clock, so each pin is checked against its neighbours
  AST_ROW_ADDR_WITH_STROBE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    row_latch_strobe_o |-> muxed_mem_addr_o == row_part)
    else $error("Row half missing under row strobe");
  AST_ROW_HELD_AT_FALL: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(row_latch_strobe_o) |-> $stable(muxed_mem_addr_o))
    else $error("Address moved as row strobe fell");
  AST_COL_WITH_BANK: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    bank_enable_o != '0 |-> muxed_mem_addr_o == col_part)
    else $error("Column half missing under bank enable");
  AST_BANK_FROM_ADDR: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    bank_enable_o != '0 |-> bank_enable_o == (BANKS'(1) << bank_sel))
    else $error("Wrong bank enabled");
  AST_DATA_ONLY_WITH_BANK: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    bank_enable_o == '0 |-> mem_data_bus_oe_o == '0)
    else $error("Data bus driven with no bank enabled");
  AST_LOW_STROBE_ENDS_IN_BANK: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(write_low_strobe_n_o) |->
      bank_enable_o != '0 && mem_data_bus_oe_o[BYTE_W-1:0] == '1)
    else $error("Low write ended without bank or data");
  AST_HIGH_STROBE_ENDS_IN_BANK: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(write_high_strobe_n_o) |->
      bank_enable_o != '0 && mem_data_bus_oe_o[DATA_W-1:BYTE_W] == '1)
    else $error("High write ended without bank or data");
  AST_READ_IN_GATE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    rsp_valid_o && byte_en != 2'b00 |-> $past(!read_low_gate_n_o || !read_high_gate_n_o))
    else $error("Read data taken outside the read gate");
  AST_MODE_GATE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    (state == IDLE) && !sram_mode_i |=> state == IDLE)
    else $error("Cycle started outside static mode");
  AST_ADDR_HELD_IN_BANK: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    bank_enable_o != '0 && $past(bank_enable_o) != '0 |-> $stable(muxed_mem_addr_o))
    else $error("Address moved while bank enabled");
  AST_RSP_PULSE: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    rsp_valid_o |=> !rsp_valid_o)
    else $error("Read response longer than one cycle");
endmodule

// >>> tb/sram_bank_model.sv
// Model: external row latch plus four banks of low/high bytewide modules
`timescale 1ns/100ps
module sram_bank_model
  import sram_bank_pkg::*;
(
  input  wire logic              row_latch_strobe_i,
  input  wire logic [MUX_W-1:0]  muxed_mem_addr_i,
  input  wire logic [BANKS-1:0]  bank_enable_i,
  input  wire logic              write_low_strobe_n_i,
  input  wire logic              write_high_strobe_n_i,
  input  wire logic              read_low_gate_n_i,
  input  wire logic              read_high_gate_n_i,
  input  wire logic [DATA_W-1:0] ctrl_data_i,
  input  wire logic [DATA_W-1:0] ctrl_oe_i,
  output logic [DATA_W-1:0]      mem_data_o
);
  // ****************************************
  // Storage, one byte array per byte lane, shared by the four banks through the key
  // ****************************************
  logic [MUX_W-1:0]  row_q = '0;
  logic [BYTE_W-1:0] mem_lo [int];
  logic [BYTE_W-1:0] mem_hi [int];
  logic [DATA_W-1:0] last_q = '0;
  logic [DATA_W-1:0] mod_q;
  logic [1:0]        drv;
  int                key;
  logic              sel;
  always @(negedge row_latch_strobe_i) row_q = muxed_mem_addr_i;
  // Bank bits sit at the top of the row; bits above the module depth alias
  assign key = int'({row_q[10:9], row_q[5:0], muxed_mem_addr_i});
  assign sel = bank_enable_i[row_q[10:9]];
  always @(posedge write_low_strobe_n_i) if (sel) mem_lo[key] = ctrl_data_i[7:0];
  always @(posedge write_high_strobe_n_i) if (sel) mem_hi[key] = ctrl_data_i[15:8];
  // ****************************************
  // Read drive; released lines show the inverse of the last value
  // ****************************************
  always @* begin
    drv   = {sel & !read_high_gate_n_i, sel & !read_low_gate_n_i};
    mod_q = ~last_q;
    if (drv[0]) mod_q[7:0] = mem_lo.exists(key) ? mem_lo[key] : 8'h5a;
    if (drv[1]) mod_q[15:8] = mem_hi.exists(key) ? mem_hi[key] : 8'ha5;
  end
  always @(posedge drv[0] or posedge drv[1]) #1 last_q = mod_q;
  always @* for (int i = 0; i < DATA_W; i++) mem_data_o[i] = ctrl_oe_i[i] ? ctrl_data_i[i] : mod_q[i];
endmodule

// >>> tb/muxed_addr_sram_bank_interface_bench.sv
// Bench: self-checking test of the SRAM bank controller against a reference model
`timescale 1ns/100ps
module muxed_addr_sram_bank_interface_bench
  import sram_bank_pkg::*;
;
  logic clk = 0, rstn = 0, mode = 1, valid = 0, wr = 0;
  logic [1:0] be = '0;
  logic [ADDR_W-1:0] addr = '0, cur = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, dbus_o, dbus_oe, dbus_i, seen_rd;
  logic ready, rvalid, rls, wln, whn, rln, rhn, seen_lo, seen_hi;
  logic [MUX_W-1:0] maddr;
  logic [BANKS-1:0] ben;
  logic [DATA_W-1:0] ref_mem [int];
  logic [31:0] seed = 32'h824e;
  logic [1:0] be_tab [3] = '{2'h1, 2'h2, 2'h3};
  int err_total = 0, check_count = 0;
  initial forever #5 clk = ~clk;
  sram_bank_ctrl dut (.core_clk_i(clk), .rstn_i(rstn), .sram_mode_i(mode), .req_valid_i(valid),
    .req_write_i(wr), .req_byte_en_i(be), .req_addr_i(addr), .req_wdata_i(wdata),
    .req_ready_o(ready), .rsp_valid_o(rvalid), .rsp_rdata_o(rdata),
    .row_latch_strobe_o(rls), .muxed_mem_addr_o(maddr), .bank_enable_o(ben),
    .write_low_strobe_n_o(wln), .write_high_strobe_n_o(whn), .read_low_gate_n_o(rln),
    .read_high_gate_n_o(rhn), .mem_data_bus_i(dbus_i), .mem_data_bus_o(dbus_o),
    .mem_data_bus_oe_o(dbus_oe));
  sram_bank_model far (.row_latch_strobe_i(rls), .muxed_mem_addr_i(maddr), .bank_enable_i(ben),
    .write_low_strobe_n_i(wln), .write_high_strobe_n_i(whn), .read_low_gate_n_i(rln),
    .read_high_gate_n_i(rhn), .ctrl_data_i(dbus_o), .ctrl_oe_i(dbus_oe), .mem_data_o(dbus_i));
  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Wire watch: row then column on the muxed bus, one bank selected
  always @(negedge clk) if (rstn) begin
    if (rls) check(maddr, cur[21:11]);
    if (|ben) begin
      check(ben, 4'h1 << cur[21:20]);
      check(maddr, cur[10:0]);
    end
    if (!wln || !rln) seen_lo = 1;
    if (!whn || !rhn) seen_hi = 1;
  end
  // ****************************************
  // One request, waited for under a bound
  // ****************************************
  task automatic run_req(input logic w, input logic [1:0] b, input logic [21:0] a,
                         input logic [15:0] d);
    int n;
    logic [15:0] m;
    m = {{8{b[1]}}, {8{b[0]}}};
    seen_lo = 0;
    seen_hi = 0;
    seen_rd = 'x;
    cur = a;
    @(posedge clk); #1;
    wr = w; be = b; addr = a; wdata = d; valid = 1;
    @(posedge clk); #1;
    valid = 0;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      if (rvalid === 1'b1) seen_rd = rdata;
      if (ready === 1'b1) break;
    end
    if (n == 40) begin
      err_total++;
      final_report();
    end else begin
      check(seen_lo, b[0]);
      check(seen_hi, b[1]);
      if (w) ref_mem[a] = (ref_mem.exists(a) ? ref_mem[a] & ~m : 16'h0000) | (d & m);
      else check(seen_rd & m, ref_mem[a] & m);
    end
  endtask
  initial begin
    logic [21:0] a;
    repeat (10) @(posedge clk);
    #1 rstn = 1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < BANKS; k++)
      run_req(1, 2'h3, {k[1:0], 3'h0, 17'(17'h1f0f0 + k)}, 16'(16'h1234 * (k + 1)));
    for (int k = 0; k < BANKS; k++)
      run_req(0, 2'h3, {k[1:0], 3'h0, 17'(17'h1f0f0 + k)}, 16'h0000);
    $display("test banks done");
    run_req(1, 2'h1, 22'h01f0f0, 16'hab00 | 16'h00cd);
    run_req(1, 2'h2, 22'h01f0f0, 16'h9900);
    run_req(1, 2'h0, 22'h01f0f0, 16'hffff);
    foreach (be_tab[i]) run_req(0, be_tab[i], 22'h01f0f0, 16'h0000);
    $display("test byte lanes done");
    @(posedge clk); #1;
    mode = 0;
    valid = 1;
    for (int n = 0; n < 30; n++) begin
      @(negedge clk);
      check({ready, ben}, 5'h00);
    end
    @(posedge clk); #1;
    valid = 0;
    mode = 1;
    $display("test mode gate done");
    for (int k = 0; k < 12; k++) begin
      seed = lfsr_next(seed);
      a = {seed[21:20], 3'h0, seed[16:0]};
      run_req(1, 2'h3, a, seed[31:16]);
      seed = lfsr_next(seed);
      run_req(0, seed[1:0] | 2'h1, a, 16'h0000);
    end
    $display("test random done");
    final_report();
  end
endmodule
